// [shared/radio_ctrl_pkg.sv]
// constants for the transceiver mode control and data port
package radio_ctrl_pkg;

  // control register map
  localparam int          NUM_REGS       = 5;
  localparam logic [6:0]  ADDR_FRONT_END = 7'h00;
  localparam logic [6:0]  ADDR_MOD_LOCK  = 7'h01;
  localparam logic [6:0]  ADDR_PUMP      = 7'h02;
  localparam logic [6:0]  ADDR_SCALE_A   = 7'h06;
  localparam logic [6:0]  ADDR_SCALE_B   = 7'h07;
  localparam int          SLOT_FRONT_END = 0;
  localparam int          SLOT_MOD_LOCK  = 1;
  localparam int          SLOT_PUMP      = 2;
  localparam int          SLOT_SCALE_A   = 3;
  localparam int          SLOT_SCALE_B   = 4;
  localparam logic [6:0]  REG_ADDR [NUM_REGS] = '{ADDR_FRONT_END, ADDR_MOD_LOCK, ADDR_PUMP,
                                                  ADDR_SCALE_A, ADDR_SCALE_B};
  // writable bit masks; reserved bits read as zero
  localparam logic [7:0]  REG_MASK [NUM_REGS] = '{8'hFF, 8'hCF, 8'hDF, 8'h7F, 8'hFF};
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // front end fields
  localparam int          FE_LOAD_BIT    = 0;
  localparam int          FE_MODE_LO     = 1;
  localparam int          FE_SYNC_BIT    = 3;
  localparam int          FE_PA_LO       = 4;
  localparam int          FE_LNA_BIT     = 7;
  // modulation and lock fields
  localparam int          ML_FILT_LO     = 0;
  localparam int          ML_LOCK_BIT    = 2;
  localparam int          ML_RSSI_BIT    = 3;
  localparam int          ML_MOD_LO      = 6;
  // pump fields
  localparam int          PU_OUTS_LO     = 0;
  localparam int          PU_PA_BY_BIT   = 4;
  localparam int          PU_SC_BY_BIT   = 6;
  localparam int          PU_HI_BIT      = 7;
  // clock scale fields
  localparam int          SA_RATE_HI_BIT = 0;
  localparam int          SA_SYNC_LO     = 1;
  localparam int          SA_MODC_LO     = 4;
  localparam int          SB_REF_LO      = 0;
  localparam int          SB_RATE_LO     = 6;

  // rate divider limits
  localparam int          REF_W          = 6;
  localparam int          SCALE_W        = 3;
  localparam int          HALF_W         = 12;
  localparam logic [5:0]  REF_MIN        = 6'h01;
  localparam logic [2:0]  SCALE_MAX      = 3'h6;

  // operating states
  typedef enum logic [1:0] {
    OP_POWER_DOWN = 2'b00,
    OP_STANDBY    = 2'b01,
    OP_RECEIVE    = 2'b10,
    OP_TRANSMIT   = 2'b11
  } op_state_t;

endpackage : radio_ctrl_pkg

// [rtl/rate_clock_gen.sv]
// programmable divider producing a bit-rate clock level and edge pulses
module rate_clock_gen
  import radio_ctrl_pkg::*;
#(
  parameter int REF_WIDTH  = REF_W,
  parameter int SCALE_BITS = SCALE_W
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_run,
  input  wire logic                  i_restart,
  input  wire logic [REF_WIDTH-1:0]  i_ref_div,
  input  wire logic [SCALE_BITS-1:0] i_scale,
  output logic                       o_level,
  output logic                       o_rise,
  output logic                       o_fall
);

  logic [HALF_W-1:0]     cnt_reg;
  logic [HALF_W-1:0]     half_cnt;
  logic [REF_WIDTH-1:0]  ref_eff;
  logic [SCALE_BITS-1:0] scale_eff;
  logic                  level_reg;
  logic                  wrap;

  // clamp illegal settings: divider 0 acts as 1, scale 7 acts as 6
  assign ref_eff   = (i_ref_div == '0) ? REF_MIN : i_ref_div;
  assign scale_eff = (i_scale > SCALE_MAX) ? SCALE_MAX : i_scale;
  // half period in cycles: ref * 2^(6 - scale), so full period is ref * 2^(7 - scale)
  assign half_cnt  = HALF_W'({6'h00, ref_eff} << (SCALE_MAX - scale_eff));
  assign wrap      = i_run && !i_restart && (cnt_reg == '0);
  assign o_rise    = wrap && !level_reg;
  assign o_fall    = wrap && level_reg;
  assign o_level   = level_reg;

  // count down the half period and toggle the clock level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end else if (!i_run || i_restart) begin
      cnt_reg   <= half_cnt - HALF_W'(1);
      level_reg <= 1'b0;
    end else if (wrap) begin
      cnt_reg   <= half_cnt - HALF_W'(1);
      level_reg <= !level_reg;
    end else begin
      cnt_reg   <= cnt_reg - HALF_W'(1);
    end
  end

endmodule // rate_clock_gen

// [rtl/transceiver_mode_and_data_port.sv]
// operating mode control, lock indicator and synchronous data port of the transceiver
// Summary of operation
// - pump current high select follows loaded bit
// - lock detector runs only when enabled
// - lock pin high while enabled and locked
// - two-bit field selects down, standby, receive, transmit
// - sync off: transparent data, clock pin idle
// - sync receive enables bit synchronizer at rate
// - sync receive drives recovered clock on pin
// - sync transmit drives programmed rate clock out
// - sync transmit samples data on rising edge
// - receive: device updates rising, host samples falling
// - rate clock is osc / (ref * 2^(7-s))
// - reference divider six bits, values 1 to 63
// - rate setting three bits, values 0 to 6
// - new values load on chip-select fall with load
module transceiver_mode_and_data_port
  import radio_ctrl_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cfg_wr,
  input  wire logic [6:0] i_cfg_addr,
  input  wire logic [7:0] i_cfg_wdata,
  input  wire logic       i_cfg_cs,
  output logic      [7:0] o_cfg_rdata,
  input  wire logic       i_pll_locked,
  input  wire logic       i_demod_data,
  input  wire logic       i_serial_data_pin,
  output logic            o_serial_data_pin,
  output logic            o_serial_data_pin_oe,
  output logic            o_bit_clock_pin,
  output logic            o_bit_clock_pin_oe,
  output logic            o_lock_indicator_pin,
  output logic            o_pump_current_high_sel,
  output logic      [1:0] o_op_state,
  output logic            o_osc_enable,
  output logic            o_rx_enable,
  output logic            o_tx_enable,
  output logic            o_mod_data
);

  logic [7:0]  shadow_reg [NUM_REGS];
  logic [7:0]  act_reg    [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic [7:0]  rd_next;
  logic        cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic        lock_s1_reg, lock_s2_reg;
  logic        dmd_s1_reg, dmd_s2_reg, dmd_s3_reg;
  logic        pin_s1_reg, pin_s2_reg;
  logic        load_pulse;
  logic        sync_en, lock_detect_enable;
  op_state_t   op_state;
  logic        in_rx, in_tx, sync_rx, sync_tx;
  logic        sync_tx_reg, sync_rx_reg;
  logic        br_level, br_rise, bs_level, bs_rise;
  logic        bs_restart, dmd_edge;
  logic        lock_reg, ser_out_reg, ser_out_next, mod_reg, mod_next;

  // register slot decode by address
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_dec
      assign hit[g] = (i_cfg_addr == REG_ADDR[g]);
    end
  endgenerate

  // chip select falls at end of a write; new values load only if load bit is set
  assign load_pulse = cs_s3_reg && !cs_s2_reg && shadow_reg[SLOT_FRONT_END][FE_LOAD_BIT];

  // shadow registers take writes, active registers take loads
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow_reg[i] <= REG_RESET;
        act_reg[i]    <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (i_cfg_wr && hit[i]) begin
          shadow_reg[i] <= i_cfg_wdata & REG_MASK[i];
        end
        if (load_pulse) begin
          act_reg[i] <= shadow_reg[i];
        end
      end
    end
  end

  // readback shows the active contents, unmapped addresses read zero
  always_comb begin
    rd_next = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (hit[i]) begin
        rd_next = act_reg[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= 8'h00;
    end else begin
      o_cfg_rdata <= rd_next;
    end
  end

  // two-stage synchronisers for pins and analog-side levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1_reg   <= 1'b0;
      cs_s2_reg   <= 1'b0;
      cs_s3_reg   <= 1'b0;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
      dmd_s1_reg  <= 1'b0;
      dmd_s2_reg  <= 1'b0;
      dmd_s3_reg  <= 1'b0;
      pin_s1_reg  <= 1'b0;
      pin_s2_reg  <= 1'b0;
    end else begin
      cs_s1_reg   <= i_cfg_cs;
      cs_s2_reg   <= cs_s1_reg;
      cs_s3_reg   <= cs_s2_reg;
      lock_s1_reg <= i_pll_locked;
      lock_s2_reg <= lock_s1_reg;
      dmd_s1_reg  <= i_demod_data;
      dmd_s2_reg  <= dmd_s1_reg;
      dmd_s3_reg  <= dmd_s2_reg;
      pin_s1_reg  <= i_serial_data_pin;
      pin_s2_reg  <= pin_s1_reg;
    end
  end

  // mode and option decode from active registers
  assign op_state           = op_state_t'(act_reg[SLOT_FRONT_END][FE_MODE_LO +: 2]);
  assign sync_en            = act_reg[SLOT_FRONT_END][FE_SYNC_BIT];
  assign lock_detect_enable = act_reg[SLOT_MOD_LOCK][ML_LOCK_BIT];
  assign in_rx              = (op_state == OP_RECEIVE);
  assign in_tx              = (op_state == OP_TRANSMIT);
  assign sync_rx            = in_rx && sync_en;
  assign sync_tx            = in_tx && sync_en;
  assign o_op_state         = op_state;
  assign o_osc_enable       = (op_state != OP_POWER_DOWN);
  assign o_rx_enable        = in_rx;
  assign o_tx_enable        = in_tx;
  assign o_pump_current_high_sel = act_reg[SLOT_PUMP][PU_HI_BIT];

  // remember sync states to find their entry
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_tx_reg <= 1'b0;
      sync_rx_reg <= 1'b0;
    end else begin
      sync_tx_reg <= sync_tx;
      sync_rx_reg <= sync_rx;
    end
  end

  // transmit bit-rate clock, restarted on entry into synchronous transmit
  rate_clock_gen u_tx_rate (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (sync_tx),
    .i_restart (sync_tx && !sync_tx_reg),
    .i_ref_div (act_reg[SLOT_SCALE_B][SB_REF_LO +: REF_W]),
    .i_scale   ({act_reg[SLOT_SCALE_A][SA_RATE_HI_BIT], act_reg[SLOT_SCALE_B][SB_RATE_LO +: 2]}),
    .o_level   (br_level),
    .o_rise    (br_rise),
    .o_fall    ()
  );

  // receive synchronizer clock, phase realigned on every received data edge
  assign dmd_edge   = dmd_s2_reg ^ dmd_s3_reg;
  assign bs_restart = (sync_rx && !sync_rx_reg) || dmd_edge;

  rate_clock_gen u_rx_sync (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (sync_rx),
    .i_restart (bs_restart),
    .i_ref_div (act_reg[SLOT_SCALE_B][SB_REF_LO +: REF_W]),
    .i_scale   (act_reg[SLOT_SCALE_A][SA_SYNC_LO +: SCALE_W]),
    .o_level   (bs_level),
    .o_rise    (bs_rise),
    .o_fall    ()
  );

  // clock pin: rate clock in sync transmit, recovered clock in sync receive, idle otherwise
  assign o_bit_clock_pin    = sync_tx ? br_level : (sync_rx ? bs_level : 1'b0);
  assign o_bit_clock_pin_oe = sync_tx || sync_rx;

  // data path next values
  assign ser_out_next = sync_rx ? (bs_rise ? dmd_s2_reg : ser_out_reg) : dmd_s2_reg;
  assign mod_next     = !in_tx ? 1'b0 : (sync_en ? (br_rise ? pin_s2_reg : mod_reg) : pin_s2_reg);

  // data and lock output flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_out_reg <= 1'b0;
      mod_reg     <= 1'b0;
      lock_reg    <= 1'b0;
    end else begin
      ser_out_reg <= ser_out_next;
      mod_reg     <= mod_next;
      lock_reg    <= lock_detect_enable && lock_s2_reg;
    end
  end

  // data pin is driven only in receive; in transmit the host owns it
  assign o_serial_data_pin    = ser_out_reg;
  assign o_serial_data_pin_oe = in_rx;
  assign o_mod_data           = mod_reg;
  assign o_lock_indicator_pin = lock_reg;

  // checks on the control and data port behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  pump_select_a: assert property (load_pulse |=> o_pump_current_high_sel == $past(shadow_reg[SLOT_PUMP][PU_HI_BIT]))
    else $error("pump select did not follow loaded bit");
  lock_gate_a: assert property (!lock_detect_enable && !load_pulse |=> !o_lock_indicator_pin)
    else $error("lock pin high while detector disabled");
  lock_show_a: assert property (lock_detect_enable && lock_s2_reg |=> o_lock_indicator_pin)
    else $error("lock pin low while enabled and locked");
  mode_load_a: assert property (load_pulse && shadow_reg[SLOT_FRONT_END][FE_MODE_LO +: 2] == 2'b11
                                |=> o_tx_enable && !o_rx_enable && o_osc_enable)
    else $error("transmit code did not select transmit");
  transparent_clk_a: assert property (!sync_en |-> !o_bit_clock_pin_oe && !o_bit_clock_pin)
    else $error("clock pin active with sync off");
  rx_clock_a: assert property (sync_rx && bs_rise && !bs_restart && !load_pulse |=> o_bit_clock_pin)
    else $error("recovered clock did not rise");
  tx_clock_oe_a: assert property (sync_tx |-> o_bit_clock_pin_oe && !o_serial_data_pin_oe)
    else $error("clock pin not driven in sync transmit");
  tx_sample_a: assert property (sync_tx && br_rise && !load_pulse |=> o_bit_clock_pin && o_mod_data == $past(pin_s2_reg))
    else $error("transmit data not sampled at clock rise");
  rx_hold_a: assert property (sync_rx && !bs_rise && !load_pulse |=> $stable(o_serial_data_pin))
    else $error("receive data changed away from clock rise");
  load_gate_a: assert property (!load_pulse |=> $stable(act_reg[SLOT_FRONT_END]) && $stable(act_reg[SLOT_PUMP]))
    else $error("active register changed without load");
  tx_restart_a: assert property (sync_tx && !sync_tx_reg |=> !o_bit_clock_pin ##1 o_bit_clock_pin_oe || !sync_tx)
    else $error("rate clock did not restart low");

  enter_sync_tx_c: cover property (sync_tx && !sync_tx_reg ##[1:300] br_rise);
  sync_rx_bit_c: cover property (sync_rx && bs_rise);
  lock_seen_c: cover property (load_pulse ##[1:50] o_lock_indicator_pin);

endmodule // transceiver_mode_and_data_port

// [bench/host_model.sv]
// host microcontroller model on the serial data port
module host_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_send,
  input  wire logic i_bit_clock,
  input  wire logic i_clk_oe,
  input  wire logic i_line,
  output logic      o_line,
  output logic      o_bit,
  output logic      o_rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_prev;
  logic float_bit;
  wire  clk_fall = clk_prev & ~i_bit_clock;
  // host data and receive sampling follow the falls of the device clock while it is driven
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_prev  <= 1'b0;
      float_bit <= 1'b0;
      o_bit     <= 1'b0;
      o_rx_bit  <= 1'b0;
    end else begin
      clk_prev  <= i_bit_clock;
      float_bit <= ~float_bit;
      // with no device clock the host times its own data every cycle
      if (clk_fall || !i_clk_oe) begin
        o_bit    <= 1'($urandom_range(1));  // new data on falls, or every cycle with no device clock
      end
      if (clk_fall) begin
        o_rx_bit <= i_line;                  // receive data taken on falls
      end
    end
  end
  // a released line wanders every cycle until sending starts
  assign o_line = i_send ? o_bit : float_bit;
endmodule // host_model

// [bench/tb.sv]
// self-checking bench for the transceiver mode control and data port
module tb
  import radio_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_cfg_wr, i_cfg_cs, i_pll_locked, i_demod_data, send, host_line, host_bit, host_rx;
  logic [6:0] i_cfg_addr;
  logic [7:0] i_cfg_wdata, o_cfg_rdata;
  logic o_serial_data_pin, o_serial_data_pin_oe, o_bit_clock_pin, o_bit_clock_pin_oe, o_lock_indicator_pin;
  logic o_pump_current_high_sel, o_osc_enable, o_rx_enable, o_tx_enable, o_mod_data;
  logic [1:0] o_op_state;
  wire pin_wire = o_serial_data_pin_oe ? o_serial_data_pin : host_line;
  int shadow [NUM_REGS];
  int act [NUM_REGS];
  int errors, compares;

  transceiver_mode_and_data_port dut (.i_clk, .i_rst_n, .i_cfg_wr, .i_cfg_addr, .i_cfg_wdata, .i_cfg_cs,
    .o_cfg_rdata, .i_pll_locked, .i_demod_data, .i_serial_data_pin(pin_wire), .o_serial_data_pin,
    .o_serial_data_pin_oe, .o_bit_clock_pin, .o_bit_clock_pin_oe, .o_lock_indicator_pin,
    .o_pump_current_high_sel, .o_op_state, .o_osc_enable, .o_rx_enable, .o_tx_enable, .o_mod_data);
  host_model host (.i_clk, .i_rst_n, .i_send(send), .i_bit_clock(o_bit_clock_pin),
    .i_clk_oe(o_bit_clock_pin_oe), .i_line(pin_wire), .o_line(host_line), .o_bit(host_bit),
    .o_rx_bit(host_rx));

  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  function automatic int slot(logic [6:0] a);
    for (int s = 0; s < NUM_REGS; s++) if (REG_ADDR[s] == a) return s;
    return -1;
  endfunction

  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pin(string n, logic e, logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
  endtask

  // shadow write; unmapped addresses leave the model untouched
  task automatic wr(logic [6:0] a, logic [7:0] d);
    int s;
    s = slot(a);
    @(posedge i_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    if (s >= 0) shadow[s] = d & REG_MASK[s];
  endtask

  // chip-select pulse; the fall copies shadow only with the load bit set
  task automatic load;
    @(posedge i_clk);
    i_cfg_cs <= 1'b1;
    tick(3);
    i_cfg_cs <= 1'b0;
    tick(6);
    if (shadow[0] & 1) act = shadow;
    #1;
  endtask

  task automatic cfg(int m, int sy, int k, int s);
    wr(ADDR_MOD_LOCK, 8'($urandom));
    wr(ADDR_PUMP, 8'($urandom));
    wr(ADDR_SCALE_A, 8'(($urandom & 8'hF0) | (s << 1) | (s >> 2)));
    wr(ADDR_SCALE_B, 8'(((s & 3) << 6) | k));
    wr(ADDR_FRONT_END, 8'(($urandom & 8'hF0) | (sy << 3) | (m << 1) | 1));
    load;
  endtask

  task automatic rd_all;
    int s;
    for (int a = 0; a < 8; a++) begin
      @(posedge i_clk) i_cfg_addr <= 7'(a);
      tick(2);
      #1 s = slot(7'(a));
      chk_reg("rdata", s < 0 ? 8'h00 : 8'(act[s]), o_cfg_rdata);
    end
  endtask

  task automatic chk_outs;
    int m, sy;
    m = (act[0] >> 1) & 3;
    sy = (act[0] >> 3) & 1;
    chk_reg("op_state", 8'(m), {6'h00, o_op_state});
    chk_pin("osc_en", m != 0, o_osc_enable);
    chk_pin("rx_en", m == 2, o_rx_enable);
    chk_pin("tx_en", m == 3, o_tx_enable);
    chk_pin("pump_hi", act[2][7], o_pump_current_high_sel);
    chk_pin("lock", act[1][2] & i_pll_locked, o_lock_indicator_pin);
    chk_pin("data_oe", m == 2, o_serial_data_pin_oe);
    chk_pin("clk_oe", sy == 1 && m >= 2, o_bit_clock_pin_oe);
    if (sy == 0) chk_pin("clk_lvl", 1'b0, o_bit_clock_pin);
  endtask

  // transparent path: output follows its source three cycles later
  task automatic run_delay(int n, bit rx);
    logic hist[$];
    repeat (n) begin
      @(posedge i_clk);
      if (rx) i_demod_data <= 1'($urandom);
      #1 hist.push_front(rx ? i_demod_data : pin_wire);
      if (hist.size() > 3) chk_pin("delayed", hist[3], rx ? o_serial_data_pin : o_mod_data);
    end
  endtask

  task automatic tx_sync(int k, int s);
    int h, cnt, rises;
    logic prev;
    h = k << (6 - s);
    send <= 1'b0;
    cfg(1, 0, k, s);
    cfg(3, 1, k, s);
    chk_pin("clk_entry", 1'b0, o_bit_clock_pin);
    send <= 1'b1;
    prev = 1'b0;
    cnt = 0;
    rises = 0;
    while (rises < 5) begin
      @(posedge i_clk);
      #1 cnt++;
      if (cnt > 2 * h + 4) begin
        errors++;
        stop_test;
      end
      if (o_bit_clock_pin && !prev) begin
        if (rises > 0) begin
          chk_reg("period", 8'(2 * h), 8'(cnt));
          chk_pin("mod_data", host_bit, o_mod_data);
        end
        rises++;
        cnt = 0;
      end
      prev = o_bit_clock_pin;
    end
  endtask

  // recovered data may only move where the recovered clock rises, carrying the bit from three cycles back
  task automatic rx_sync;
    logic pc, pd, pf;
    logic hist[$];
    int n;
    cfg(2, 1, 2, 6);
    pc = o_bit_clock_pin;
    pd = o_serial_data_pin;
    pf = 1'b0;
    n = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge i_clk);
      if (i % 16 == 0) i_demod_data <= 1'($urandom);
      #1 hist.push_front(i_demod_data);
      n += int'(o_bit_clock_pin & ~pc);
      if (o_serial_data_pin !== pd) chk_pin("rx_on_rise", 1'b1, o_bit_clock_pin & ~pc);
      if (o_bit_clock_pin && !pc && hist.size() > 3) chk_pin("rx_data", hist[3], o_serial_data_pin);
      if (pf) chk_pin("rx_host", o_serial_data_pin, host_rx);
      pf = pc && !o_bit_clock_pin;
      pc = o_bit_clock_pin;
      pd = o_serial_data_pin;
    end
    chk_pin("rx_clk_runs", 1'b1, n > 0);
  endtask

  initial begin
    static int ks [5] = '{4, 3, 63, 1, 1};
    static int ss [5] = '{6, 5, 6, 2, 0};
    void'($urandom(25962));
    {i_rst_n, i_cfg_wr, i_cfg_cs, i_pll_locked, i_demod_data, send} = 6'h00;
    i_cfg_addr = 7'h00;
    i_cfg_wdata = 8'h00;
    foreach (act[i]) {act[i], shadow[i]} = {32'h0, 32'h0};
    tick(6);
    i_rst_n <= 1'b1;
    tick(2);
    #1 chk_outs;
    rd_all;
    wr(ADDR_FRONT_END, 8'hF6);
    wr(7'h05, 8'hFF);
    load;
    chk_outs;
    rd_all;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk) i_pll_locked <= 1'($urandom);
      cfg(i % 4, i / 4, 4, 6);
      chk_outs;
      rd_all;
    end
    cfg(2, 0, 1, 6);
    run_delay(40, 1'b1);
    send <= 1'b1;
    cfg(3, 0, 1, 6);
    chk_outs;
    run_delay(40, 1'b0);
    for (int i = 0; i < 5; i++) tx_sync(ks[i], ss[i]);
    send <= 1'b0;
    rx_sync;
    @(posedge i_clk) i_rst_n <= 1'b0;
    tick(2);
    i_rst_n <= 1'b1;
    foreach (act[i]) {act[i], shadow[i]} = {32'h0, 32'h0};
    tick(2);
    #1 chk_outs;
    rd_all;
    stop_test;
  end
endmodule // tb
